// File: led_ctrl_consts.svh
// timing counts, register offsets, field positions and the strap settle count
`ifndef LED_CTRL_CONSTS_SVH
`define LED_CTRL_CONSTS_SVH

`define CLK_FREQ_HZ        20000000
`define STRETCH_TIME_MS    80
`define STRETCH_CYCLES     ((`CLK_FREQ_HZ / 1000) * `STRETCH_TIME_MS)
`define PRESCALE_CYCLES    20000
`define STRETCH_TICKS      (`STRETCH_CYCLES / `PRESCALE_CYCLES)
// edges after reset release before the second sync stage holds the straps
`define STRAP_SETTLE       2'h2

`define LED_CONFIGURATION_ADDR       12'h000
`define LED_STATUS_ADDR    12'h004
`define LED_PIN_ENABLE_LSB         0
`define LED_PIN_ENABLE_MSB         7
`define LED_FUNCTION_SELECT_LSB        8
`define LED_FUNCTION_SELECT_MSB        9

`endif

// File: led_ctrl_pkg.sv
// types for the port led indicator controller
package led_ctrl_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PULSE = 4'b0010,
		ST_HOLD = 4'b0100,
		ST_SPARE = 4'b1000
	} stretch_e;

	typedef logic [1:0] fun_t;

endpackage

// File: port_led_indicator_ctrl.sv
// led indicator controller: strap loading, apb config, stretchers, pin map
`timescale 1ns/1ns
`include "led_ctrl_consts.svh"

module port_led_indicator_ctrl #(
	parameter int PRESCALE = `PRESCALE_CYCLES,
	parameter int TICKS    = `STRETCH_TICKS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  function_select_strap,
	input  wire logic [7:0]  pin_enable_strap,
	input  wire logic [1:0]  link_up,
	input  wire logic [1:0]  speed_100,
	input  wire logic [1:0]  full_duplex,
	input  wire logic [1:0]  collision,
	input  wire logic [1:0]  port_tx_en,
	input  wire logic [1:0]  port_rx_dv,
	input  wire logic        host_tx_en,
	input  wire logic        host_rx_dv,
	input  wire logic [7:0]  gpio_out,
	input  wire logic [7:0]  gpio_oe,
	output logic      [7:0]  led_pin_out,
	output logic      [7:0]  led_pin_oe,
	output logic      [7:0]  led_mode
);

	////////////////////////////////////////////////////////////////////
	// state and constants

	localparam int NS = 8;
	localparam int PW = $clog2(PRESCALE + 1);
	localparam int TW = $clog2(TICKS + 1);

	// stretcher index: 0 host tx, 1 host rx, 2/3 activity p1/p2,
	// 4/5 collision p1/p2; 6,7 spare
	typedef struct packed {
		logic                         strap_done;
		logic [1:0]                   strap_wait;
		logic [7:0]                   led_pin_enable;
		led_ctrl_pkg::fun_t           led_function_select;
		logic [PW-1:0]                prescale;
		logic                         tick;
		led_ctrl_pkg::stretch_e [NS-1:0] st;
		logic [NS-1:0][TW-1:0]        cnt;
		logic [NS-1:0]                pend;
		logic [7:0]                   pin_out;
		logic [7:0]                   pin_oe;
		logic [7:0]                   mode;
		logic [31:0]                  rdata;
		logic                         ready;
		logic                         err;
	} state_s;

	state_s r_q;
	state_s r_d;

	////////////////////////////////////////////////////////////////////
	// input synchronisers: everything here comes from pins or other logic

	logic [23:0] sync1_q;
	logic [23:0] sync2_q;
	logic [23:0] raw_in;

	assign raw_in = {pin_enable_strap, function_select_strap, link_up,
		speed_100, full_duplex, collision, port_tx_en, port_rx_dv,
		host_tx_en, host_rx_dv};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 24'h000000;
			sync2_q <= 24'h000000;
		end else begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	logic [7:0] s_en_strap;
	logic [1:0] s_fun_strap;
	logic [1:0] s_link;
	logic [1:0] s_100;
	logic [1:0] s_fd;
	logic [1:0] s_col;
	logic [1:0] s_ptx;
	logic [1:0] s_prx;
	logic       s_htx;
	logic       s_hrx;

	assign {s_en_strap, s_fun_strap, s_link, s_100, s_fd, s_col, s_ptx,
		s_prx, s_htx, s_hrx} = sync2_q;

	// activity triggers feeding each stretcher
	// each trigger is a level; a stretcher starts on it from idle and
	// in the hold-off remembers it as pending, so a burst that lands in the
	// hold-off still gives one more pulse once the hold-off ends
	// activity and collision only count while the port has a link, so a
	// dead port never shows a stretched pulse
	logic [NS-1:0] trig;
	logic [1:0]    port_act;

	assign port_act = s_ptx | s_prx;
	assign trig = {2'b00, s_col & ~s_fd & s_link, port_act & s_link,
		s_hrx, s_htx};

	////////////////////////////////////////////////////////////////////
	// next state

	logic [7:0] ind;

	always_comb begin
		logic [NS-1:0] pulse;
		logic          rd;
		logic          wr;
		pulse = '0;
		rd = 1'b0;
		wr = 1'b0;
		r_d = r_q;
		r_d.ready = 1'b0;
		r_d.err = 1'b0;

		// straps are caught once the synchroniser holds them: stage two
		// still shows its reset value for the first two edges after
		// release, and loading then would leave every pin dark
		// software writes before the load are dropped, so the straps
		// always win the race against an early configuration write
		if (!r_q.strap_done) begin
			if (r_q.strap_wait == `STRAP_SETTLE) begin
				r_d.led_pin_enable = s_en_strap;
				r_d.led_function_select = s_fun_strap;
				r_d.strap_done = 1'b1;
			end else begin
				r_d.strap_wait = r_q.strap_wait + 2'h1;
			end
		end

		// apb: one wait state, answer in the second access cycle
		// the register update lands with the edge that raises pready;
		// the master holds address and data until it sees pready, so
		// nothing it drives can change underneath the update
		// unmapped offsets answer with an error and zero data
		if (psel && penable && !r_q.ready) begin
			r_d.ready = 1'b1;
			rd = !pwrite;
			wr = pwrite;
			case (paddr)
			`LED_CONFIGURATION_ADDR: begin
				r_d.rdata = 32'h0;
				r_d.rdata[`LED_PIN_ENABLE_MSB:`LED_PIN_ENABLE_LSB] = r_q.led_pin_enable;
				r_d.rdata[`LED_FUNCTION_SELECT_MSB:`LED_FUNCTION_SELECT_LSB] =
					r_q.led_function_select;
				if (wr && r_q.strap_done) begin
					r_d.led_pin_enable =
						pwdata[`LED_PIN_ENABLE_MSB:`LED_PIN_ENABLE_LSB];
					r_d.led_function_select =
						pwdata[`LED_FUNCTION_SELECT_MSB:`LED_FUNCTION_SELECT_LSB];
				end
			end
			`LED_STATUS_ADDR: begin
				r_d.rdata = {24'h000000, r_q.pin_out};
			end
			default: begin
				r_d.rdata = 32'h0;
				r_d.err = 1'b1;
			end
			endcase
			if (!rd && paddr != `LED_CONFIGURATION_ADDR && paddr != `LED_STATUS_ADDR)
				r_d.rdata = 32'h0;
		end

		// prescaler: one tick per PRESCALE cycles
		r_d.tick = 1'b0;
		if (r_q.prescale == PW'(PRESCALE - 1)) begin
			r_d.prescale = '0;
			r_d.tick = 1'b1;
		end else begin
			r_d.prescale = r_q.prescale + PW'(1);
		end

		// stretchers: pulse for TICKS ticks, hold off for TICKS ticks
		// the prescaler runs free, so the first tick of a pulse may come
		// up to one prescale period early; the pulse is therefore up to
		// one tick short, which is far below what the eye can see
		// the hold-off always starts on a tick and so lasts full length
		for (int i = 0; i < NS; i++) begin
			if (trig[i])
				r_d.pend[i] = 1'b1;
			case (r_q.st[i])
			led_ctrl_pkg::ST_IDLE: begin
				if (trig[i] || r_q.pend[i]) begin
					r_d.st[i] = led_ctrl_pkg::ST_PULSE;
					r_d.cnt[i] = '0;
					r_d.pend[i] = 1'b0;
				end
			end
			led_ctrl_pkg::ST_PULSE: begin
				pulse[i] = 1'b1;
				if (r_q.tick) begin
					if (r_q.cnt[i] == TW'(TICKS - 1)) begin
						r_d.st[i] = led_ctrl_pkg::ST_HOLD;
						r_d.cnt[i] = '0;
					end else begin
						r_d.cnt[i] = r_q.cnt[i] + TW'(1);
					end
				end
				// activity during the pulse is absorbed by it
				if (!trig[i])
					r_d.pend[i] = 1'b0;
			end
			led_ctrl_pkg::ST_HOLD: begin
				if (r_q.tick) begin
					if (r_q.cnt[i] == TW'(TICKS - 1)) begin
						r_d.st[i] = led_ctrl_pkg::ST_IDLE;
						r_d.cnt[i] = '0;
					end else begin
						r_d.cnt[i] = r_q.cnt[i] + TW'(1);
					end
				end
			end
			default: begin
				r_d.st[i] = led_ctrl_pkg::ST_IDLE;
				r_d.cnt[i] = '0;
			end
			endcase
		end

		// indications as pin levels, 1 = released (off)
		// link/activity style indications are lit while linked and go
		// dark for the stretch; plain activity and collision are dark
		// and light up for the stretch
		// raw transmit and receive levels in map 11 bypass the stretchers
		ind = 8'hff;
		case (r_q.led_function_select)
		2'b00: begin
			ind[7] = ~pulse[1];
			ind[6] = ~s_link[1] | pulse[3];
			ind[5] = ~s_link[1] | (~s_fd[1] & ~pulse[5]);
			ind[4] = ~(s_link[1] & s_100[1]);
			ind[3] = ~pulse[0];
			ind[2] = ~s_link[0] | pulse[2];
			ind[1] = ~s_link[0] | (~s_fd[0] & ~pulse[4]);
			ind[0] = ~(s_link[0] & s_100[0]);
		end
		2'b01: begin
			ind[7] = ~pulse[1];
			ind[6] = ~(s_link[1] & s_100[1]) | pulse[3];
			ind[5] = ~s_link[1] | (~s_fd[1] & ~pulse[5]);
			ind[4] = ~(s_link[1] & ~s_100[1]) | pulse[3];
			ind[3] = ~pulse[0];
			ind[2] = ~(s_link[0] & s_100[0]) | pulse[2];
			ind[1] = ~s_link[0] | (~s_fd[0] & ~pulse[4]);
			ind[0] = ~(s_link[0] & ~s_100[0]) | pulse[2];
		end
		2'b10: begin
			ind[7] = ~(s_link[1] & pulse[3]);
			ind[6] = ~s_link[1];
			ind[5] = ~s_link[1] | (~s_fd[1] & ~pulse[5]);
			ind[4] = ~(s_link[1] & s_100[1]);
			ind[3] = ~(s_link[0] & pulse[2]);
			ind[2] = ~s_link[0];
			ind[1] = ~s_link[0] | (~s_fd[0] & ~pulse[4]);
			ind[0] = ~(s_link[0] & s_100[0]);
		end
		2'b11: begin
			// pins 7,6 keep the released default
			ind[5] = ~s_ptx[1];
			ind[4] = ~s_prx[1];
			ind[3] = ~s_htx;
			ind[2] = ~s_hrx;
			ind[1] = ~s_ptx[0];
			ind[0] = ~s_prx[0];
		end
		default: ind = 8'hff;
		endcase

		// pin mux: led mode drives open-drain low only, else gpio owns it
		// the output value stays low in led mode and only the enable
		// moves, so a pin can never be driven high against the pull-up
		// of a lamp that shares a supply with other parts
		// the choice between gpio and led follows the enable register
		// with one cycle of latency, like every other output here
		for (int p = 0; p < 8; p++) begin
			if (r_q.led_pin_enable[p]) begin
				r_d.mode[p] = 1'b1;
				r_d.pin_out[p] = 1'b0;
				r_d.pin_oe[p] = ~ind[p];
			end else begin
				r_d.mode[p] = 1'b0;
				r_d.pin_out[p] = gpio_out[p];
				r_d.pin_oe[p] = gpio_oe[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q.strap_done <= 1'b0;
			r_q.strap_wait <= 2'h0;
			r_q.led_pin_enable <= 8'h00;
			r_q.led_function_select <= 2'h0;
			r_q.prescale <= '0;
			r_q.tick <= 1'b0;
			r_q.st <= {NS{led_ctrl_pkg::ST_IDLE}};
			r_q.cnt <= '0;
			r_q.pend <= '0;
			r_q.pin_out <= 8'h00;
			r_q.pin_oe <= 8'h00;
			r_q.mode <= 8'h00;
			r_q.rdata <= 32'h0;
			r_q.ready <= 1'b0;
			r_q.err <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// every output below is a field of the state register
	assign prdata = r_q.rdata;
	assign pready = r_q.ready;
	assign pslverr = r_q.err;
	assign led_pin_out = r_q.pin_out;
	assign led_pin_oe = r_q.pin_oe;
	assign led_mode = r_q.mode;

endmodule // port_led_indicator_ctrl

// File: led_far_side.sv
// far-side model: pull-up on every shared pin, lamp lit while pulled low
`timescale 1ns/1ns

module led_far_side (
	input  wire logic [7:0] led_pin_out,
	input  wire logic [7:0] led_pin_oe,
	output logic      [7:0] pin_level
);
	// a released pin floats to the pull-up, so a dark lamp reads high
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_level[i] = led_pin_oe[i] ? led_pin_out[i] : 1'b1;
		end
	end
endmodule // led_far_side

// File: led_ctrl_properties.sv
// assertions on the led controller's apb and pin ports
`timescale 1ns/1ns

module led_ctrl_checker #(
	parameter int PRESCALE = 4,
	parameter int TICKS    = 3
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  led_pin_out,
	input wire logic [7:0]  led_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       start;
	logic       hit;
	logic [7:0] en_q;
	assign start = psel && penable && !pready;
	assign hit = paddr == 12'h000 || paddr == 12'h004;
	// last enable byte written, kept so a late pin update can be checked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en_q <= 8'h00;
		else if (pready && pwrite && paddr == 12'h000)
			en_q <= pwdata[7:0];
	end
	ready_one_wait_a: assert property (start |=> pready)
		else $error("ready not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	no_setup_ready_a: assert property (psel && !penable |-> !pready)
		else $error("ready during setup");
	unmapped_err_a: assert property (start && !hit |=> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (start && hit |=> !pslverr)
		else $error("mapped access refused");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	led_low_drive_a: assert property ((led_pin_out & led_mode) == 8'h00)
		else $error("led pin drives high");
	enable_write_a: assert property (pready && pwrite && paddr == 12'h000
		|-> ##[1:3] led_mode == en_q) else $error("pin enables not applied");
endmodule // led_ctrl_checker

bind port_led_indicator_ctrl led_ctrl_checker #(.PRESCALE(PRESCALE),
	.TICKS(TICKS)) led_ctrl_checker_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.led_pin_out(led_pin_out), .led_mode(led_mode));

// File: testbench.sv
// self-checking testbench for the port led indicator controller
`timescale 1ns/1ns

module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        host_tx_en, host_rx_dv;
	logic [1:0]  link_up, speed_100, full_duplex, collision;
	logic [1:0]  port_tx_en, port_rx_dv;
	logic [7:0]  gpio_out, gpio_oe, led_pin_out, led_pin_oe, led_mode;
	logic [7:0]  pin_level;
	logic [7:0]  tab [4] = '{8'h65, 8'h34, 8'h65, 8'h00};
	int          n_mismatch, cmp_count, n;

	port_led_indicator_ctrl #(.PRESCALE(4), .TICKS(3))
		port_led_indicator_ctrl_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.function_select_strap(2'b10), .pin_enable_strap(8'hff),
		.link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
		.collision(collision), .port_tx_en(port_tx_en),
		.port_rx_dv(port_rx_dv), .host_tx_en(host_tx_en),
		.host_rx_dv(host_rx_dv), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.led_pin_out(led_pin_out), .led_pin_oe(led_pin_oe),
		.led_mode(led_mode));
	led_far_side led_far_side_inst (.led_pin_out(led_pin_out),
		.led_pin_oe(led_pin_oe), .pin_level(pin_level));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// entered just after a rising edge; holds the request until pready
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] exp, input logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!wr)
			check(prdata, exp);
		check({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic lamps(input logic [7:0] exp);
		repeat (6) @(posedge pclk);
		check({24'h0, ~pin_level}, {24'h0, exp});
	endtask
	// counts cycles a pin spends at lvl, once it gets there
	task automatic pulse_len(input int i, input logic lvl);
		n = 0;
		while (pin_level[i] !== lvl) @(posedge pclk);
		while (pin_level[i] === lvl) begin
			n++;
			@(posedge pclk);
		end
		check({31'h0, n >= 8 && n <= 16}, 32'h1);
	endtask
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_mismatch++;
		summarize();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{host_tx_en, host_rx_dv, link_up, speed_100, full_duplex} = '0;
		{collision, port_tx_en, port_rx_dv, gpio_out, gpio_oe} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, 12'h000, 32'h0, 32'h0000_02ff, 1'b0);
		apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
		link_up <= 2'b11;
		speed_100 <= 2'b01;
		full_duplex <= 2'b10;
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h000, {22'h0, m[1:0], 8'hff}, 32'h0, 1'b0);
			lamps(tab[m]);
		end
		apb(1'b0, 12'h000, 32'h0, 32'h0000_03ff, 1'b0);
		port_tx_en <= 2'b10;
		port_rx_dv <= 2'b01;
		host_tx_en <= 1'b1;
		lamps(8'h29);
		{port_tx_en, port_rx_dv, host_tx_en} <= '0;
		lamps(8'h00);
		apb(1'b1, 12'h000, 32'h0000_00ff, 32'h0, 1'b0);
		link_up <= 2'b00;
		lamps(8'h00);
		link_up <= 2'b11;
		lamps(8'h65);
		apb(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
		host_rx_dv <= 1'b1;
		@(posedge pclk);
		host_rx_dv <= 1'b0;
		pulse_len(7, 1'b0);
		collision <= 2'b01;
		@(posedge pclk);
		collision <= 2'b00;
		pulse_len(1, 1'b0);
		host_tx_en <= 1'b1;
		@(posedge pclk);
		host_tx_en <= 1'b0;
		pulse_len(3, 1'b0);
		host_tx_en <= 1'b1;
		@(posedge pclk);
		host_tx_en <= 1'b0;
		pulse_len(3, 1'b1);
		port_rx_dv <= 2'b01;
		@(posedge pclk);
		port_rx_dv <= 2'b00;
		pulse_len(2, 1'b1);
		gpio_out <= 8'ha5;
		gpio_oe <= 8'h3c;
		apb(1'b1, 12'h000, 32'h0000_000f, 32'h0, 1'b0);
		repeat (6) @(posedge pclk);
		check({24'h0, led_mode}, 32'h0000_000f);
		check({24'h0, led_pin_oe[7:4], led_pin_out[7:4]}, 32'h3a);
		summarize();
	end
endmodule // testbench
